/* File: hdl/aport_pkg.sv */
package aport_pkg;
    // serializer count and data word width
    localparam int unsigned NUM_SER       = 8;
    localparam int unsigned DATA_W        = 32;
    // words held between dedicated port and serializer buffers
    localparam int unsigned FIFO_DEPTH    = 4;
    // port system clock figure and request latency bound
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned REQ_LAT_CLKS  = 5;
    // setup before a buffer is needed: clocks plus bit clocks
    localparam int unsigned SETUP_CLKS    = 3;
    localparam int unsigned SETUP_BCLKS   = 4;
    // port select encodings
    localparam logic        SEL_DATA_PORT = 1'b0;
    localparam logic        SEL_CFG_BUS   = 1'b1;
    // reset values
    localparam logic        FLAG_RST      = 1'b0;
    localparam logic        REQ_RST       = 1'b0;
    localparam logic        ERR_RST       = 1'b0;
    // masks start all serviced so the first slot reports no error
    localparam logic        MARK_RST      = 1'b1;
endpackage

/* File: hdl/audio_port_buffer_service.sv */
`timescale 1ns/1ps

// small first-in first-out store with valid/ready on both sides
module aport_fifo
#(
    parameter int unsigned W = 32,
    parameter int unsigned D = 4
)
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int unsigned PW = (D > 1) ? $clog2(D) : 1;

    initial
    begin
        if (D < 2 || (D & (D - 1)) != 0)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0]  mem_r [D];   // word storage
    logic [PW-1:0] wr_ptr_r;    // next slot to fill
    logic [PW-1:0] rd_ptr_r;    // oldest word
    logic [PW:0]   count_r;     // words held
    wire           push_w;
    wire           pop_w;

    assign in_ready  = (count_r != (PW+1)'(D)); // full stalls source
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push_w    = in_valid && in_ready;
    assign pop_w     = out_valid && out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push_w)
            mem_r[wr_ptr_r] <= in_data;
    end

    // pointers and occupancy
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_r + PW'(push_w);
            rd_ptr_r <= rd_ptr_r + PW'(pop_w);
            count_r  <= count_r + (PW+1)'(push_w) - (PW+1)'(pop_w);
        end
    end
endmodule

// What this block does
// - set tx ready on buffer-to-shift move, clear
// - set rx ready on shift-to-buffer move
// - clear rx ready by write-one or all read
// - each rx ready setting issues rx request
// - rx interrupt only when its enable set
// - new transfer requests again, flag already set
// - one request per direction, all serializers
// - request within five clocks of last bit
// - one request per direction each time slot
// - data port steps through active serializers
// - data port reads active receivers ascending
// - config bus uses exact serializer address
// - flag underrun when transmitter left unwritten
// - flag overrun when receiver left unread
// - any buffer read counts, even debugger
// - any buffer write counts, even debugger
// - requests follow each rising ready flag
module audio_port_buffer_service
#(
    parameter int unsigned N  = aport_pkg::NUM_SER,
    parameter int unsigned W  = aport_pkg::DATA_W,
    parameter int unsigned FD = aport_pkg::FIFO_DEPTH
)
(
    input  wire logic                 REF_CLK,
    input  wire logic                 SRST,
    // line side, outside this clock's domain
    input  wire logic                 TX_BIT_CLOCK,
    input  wire logic                 TX_SLOT_END,
    input  wire logic                 RX_SLOT_END,
    input  wire logic [N-1:0][W-1:0]  RX_SHIFT_DATA,
    output logic      [N-1:0][W-1:0]  TX_SHIFT_DATA,
    // configuration
    input  wire logic [N-1:0]         SER_ACTIVE,
    input  wire logic [N-1:0]         SER_IS_TX,
    input  wire logic                 TX_PORT_SELECT,
    input  wire logic                 RX_PORT_SELECT,
    input  wire logic                 TX_IRQ_ENABLE,
    input  wire logic                 RX_IRQ_ENABLE,
    input  wire logic                 TX_READY_CLEAR,
    input  wire logic                 RX_READY_CLEAR,
    input  wire logic                 ERR_CLEAR,
    // status and requests
    output logic                      TX_READY_FLAG,
    output logic                      RX_READY_FLAG,
    output logic                      TX_DMA_REQUEST,
    output logic                      RX_DMA_REQUEST,
    output logic                      TX_IRQ,
    output logic                      RX_IRQ,
    output logic                      TX_UNDERRUN,
    output logic                      RX_OVERRUN,
    // dedicated data port, one address for all serializers
    input  wire logic                 DP_WR_VALID,
    output logic                      DP_WR_READY,
    input  wire logic [W-1:0]         DP_WR_DATA,
    input  wire logic                 DP_RD_REQ,
    output logic                      DP_RD_VALID,
    output logic      [W-1:0]         DP_RD_DATA,
    // configuration bus, one address per serializer
    input  wire logic [$clog2(N)-1:0] CB_ADDR,
    input  wire logic                 CB_WR,
    input  wire logic [W-1:0]         CB_WDATA,
    input  wire logic                 CB_RD,
    output logic                      CB_RVALID,
    output logic      [W-1:0]         CB_RDATA
);
    localparam int unsigned IW = $clog2(N);

    initial
    begin
        if (N < 2 || N > 16)
            $error("serializer count must lie between 2 and 16");
    end

    // lowest pending serializer: {found, index}
    function automatic logic [IW:0] lowest(input logic [N-1:0] m);
        logic [IW:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--)
            if (m[i])
                r = {1'b1, IW'(i)};
        return r;
    endfunction

    // two-stage synchronisers for line-side inputs
    logic [2:0]          bclk_s_r;     // stage 3 only for edge detect
    logic [1:0]          txend_s_r;
    logic [1:0]          rxend_s_r;
    logic [N-1:0][W-1:0] rxd_s1_r;
    logic [N-1:0][W-1:0] rxd_s2_r;

    // serializer buffers and service masks
    logic [N-1:0][W-1:0] ser_buf_r;    // one buffer per serializer
    logic [N-1:0]        tx_wr_r;      // written this slot
    logic [N-1:0]        rx_rd_r;      // read this slot

    wire                 bclk_rise_w;
    wire                 tx_evt;       // buffers moved into shifters
    wire                 rx_evt;       // shifters moved into buffers
    wire  [N-1:0]        tx_act;
    wire  [N-1:0]        rx_act;
    wire  [N-1:0]        tx_pend;
    wire  [N-1:0]        rx_pend;
    wire  [IW:0]         tx_pick;
    wire  [IW:0]         rx_pick;
    wire                 fifo_valid;
    wire  [W-1:0]        fifo_data;
    wire                 fifo_pop;
    wire                 dp_wr_en;
    wire                 dp_rd_take;
    wire                 cb_wr_take;
    wire                 cb_rd_take;
    wire  [W-1:0]        rd_pick_w;
    wire                 tx_flag_nxt;
    wire                 rx_flag_nxt;

    // slot ends are sampled on the synchronised bit clock edge;
    // this costs three clocks, leaving room inside the bound
    assign bclk_rise_w = bclk_s_r[1] && !bclk_s_r[2];
    assign tx_evt      = bclk_rise_w && txend_s_r[1];
    assign rx_evt      = bclk_rise_w && rxend_s_r[1];

    assign tx_act  = SER_ACTIVE & SER_IS_TX;
    assign rx_act  = SER_ACTIVE & ~SER_IS_TX;
    assign tx_pend = tx_act & ~tx_wr_r;
    assign rx_pend = rx_act & ~rx_rd_r;
    assign tx_pick = lowest(tx_pend);
    assign rx_pick = lowest(rx_pend);

    // data port is honoured only while selected
    assign dp_wr_en   = (TX_PORT_SELECT == aport_pkg::SEL_DATA_PORT);
    assign fifo_pop   = fifo_valid && tx_pick[IW] && !tx_evt;
    assign dp_rd_take = DP_RD_REQ && rx_pick[IW] && !rx_evt &&
                        (RX_PORT_SELECT == aport_pkg::SEL_DATA_PORT);
    assign cb_wr_take = CB_WR && (TX_PORT_SELECT == aport_pkg::SEL_CFG_BUS);
    assign cb_rd_take = CB_RD && (RX_PORT_SELECT == aport_pkg::SEL_CFG_BUS);
    assign rd_pick_w  = ser_buf_r[rx_pick[IW-1:0]];

    // set wins over clear; all-serviced clear needs an active set
    assign tx_flag_nxt = tx_evt ? 1'b1 :
                         (TX_READY_CLEAR ||
                          (tx_act != '0 && tx_pend == '0)) ? 1'b0 :
                         TX_READY_FLAG;
    assign rx_flag_nxt = rx_evt ? 1'b1 :
                         (RX_READY_CLEAR ||
                          (rx_act != '0 && rx_pend == '0)) ? 1'b0 :
                         RX_READY_FLAG;

    // interrupts gated by their enables
    assign TX_IRQ = TX_READY_FLAG && TX_IRQ_ENABLE;
    assign RX_IRQ = RX_READY_FLAG && RX_IRQ_ENABLE;

    // write words wait here until a transmitter is pending
    aport_fifo #(.W(W), .D(FD)) u_wr_fifo
    (
        .clk       (REF_CLK),
        .srst      (SRST),
        .in_valid  (DP_WR_VALID && dp_wr_en),
        .in_ready  (DP_WR_READY),
        .in_data   (DP_WR_DATA),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // synchronisers; first stages feed only second stages
    always_ff @(posedge REF_CLK)
    begin
        bclk_s_r  <= {bclk_s_r[1:0], TX_BIT_CLOCK};
        txend_s_r <= {txend_s_r[0], TX_SLOT_END};
        rxend_s_r <= {rxend_s_r[0], RX_SLOT_END};
        rxd_s1_r  <= RX_SHIFT_DATA;
        rxd_s2_r  <= rxd_s1_r;
    end

    // serializer buffers: capture, data port and config bus writes
    always_ff @(posedge REF_CLK)
    begin
        for (int i = 0; i < N; i++)
            if (rx_evt && rx_act[i])
                ser_buf_r[i] <= rxd_s2_r[i];
        if (fifo_pop)
            ser_buf_r[tx_pick[IW-1:0]] <= fifo_data;
        if (cb_wr_take)
            ser_buf_r[CB_ADDR] <= CB_WDATA;
    end

    // shifters load every transmit buffer at once
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            TX_SHIFT_DATA <= '0;
        else if (tx_evt)
            for (int i = 0; i < N; i++)
                if (tx_act[i])
                    TX_SHIFT_DATA[i] <= ser_buf_r[i];
    end

    // transmit service mask; any write counts, debugger included
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            tx_wr_r <= {N{aport_pkg::MARK_RST}};
        else if (tx_evt)
            tx_wr_r <= '0;
        else
        begin
            if (fifo_pop)
                tx_wr_r[tx_pick[IW-1:0]] <= 1'b1;
            if (cb_wr_take)
                tx_wr_r[CB_ADDR] <= 1'b1;
        end
    end

    // receive service mask; any read counts, debugger included
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            rx_rd_r <= {N{aport_pkg::MARK_RST}};
        else if (rx_evt)
            rx_rd_r <= '0;
        else
        begin
            if (dp_rd_take)
                rx_rd_r[rx_pick[IW-1:0]] <= 1'b1;
            if (cb_rd_take)
                rx_rd_r[CB_ADDR] <= 1'b1;
        end
    end

    // flags and one request pulse per slot per direction
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            TX_READY_FLAG  <= aport_pkg::FLAG_RST;
            RX_READY_FLAG  <= aport_pkg::FLAG_RST;
            TX_DMA_REQUEST <= aport_pkg::REQ_RST;
            RX_DMA_REQUEST <= aport_pkg::REQ_RST;
        end
        else
        begin
            TX_READY_FLAG  <= tx_flag_nxt;
            RX_READY_FLAG  <= rx_flag_nxt;
            // pulse on the event itself, so a flag left set still
            // produces a fresh request
            TX_DMA_REQUEST <= tx_evt;
            RX_DMA_REQUEST <= rx_evt;
        end
    end

    // sticky late-service errors, set wins over clear
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            TX_UNDERRUN <= aport_pkg::ERR_RST;
            RX_OVERRUN  <= aport_pkg::ERR_RST;
        end
        else
        begin
            TX_UNDERRUN <= (tx_evt && tx_pend != '0) ||
                           (TX_UNDERRUN && !ERR_CLEAR);
            RX_OVERRUN  <= (rx_evt && rx_pend != '0) ||
                           (RX_OVERRUN && !ERR_CLEAR);
        end
    end

    // read answers one clock after the request
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            DP_RD_VALID <= 1'b0;
            DP_RD_DATA  <= '0;
            CB_RVALID   <= 1'b0;
            CB_RDATA    <= '0;
        end
        else
        begin
            DP_RD_VALID <= dp_rd_take;
            CB_RVALID   <= cb_rd_take;
            if (dp_rd_take)
                DP_RD_DATA <= rd_pick_w;
            if (cb_rd_take)
                CB_RDATA <= ser_buf_r[CB_ADDR];
        end
    end

    default clocking cb_main @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    sequence s_tx_evt;
        tx_evt;
    endsequence
    sequence s_tx_raise;
        TX_READY_FLAG && TX_DMA_REQUEST;
    endsequence

    property p_tx_req;
        s_tx_evt |=> s_tx_raise;
    endproperty
    a_tx_req: assert property (p_tx_req)
        else $error("tx request or flag missing after transfer");

    property p_rx_req;
        rx_evt |-> ##1 RX_DMA_REQUEST
            ##0 RX_READY_FLAG;
    endproperty
    a_rx_req: assert property (p_rx_req)
        else $error("rx request missing after capture");

    property p_rx_irq;
        RX_IRQ |-> RX_READY_FLAG && RX_IRQ_ENABLE;
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("rx interrupt without flag and enable");

    property p_rx_clr;
        RX_READY_CLEAR && !rx_evt |=> !RX_READY_FLAG;
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("rx flag survived write-one clear");

    property p_tx_all;
        TX_READY_FLAG && tx_act != '0 && tx_pend == '0 && !tx_evt
            |=> !TX_READY_FLAG;
    endproperty
    a_tx_all: assert property (p_tx_all)
        else $error("tx flag kept after all transmitters written");

    property p_under;
        tx_evt && tx_pend != '0 |=> TX_UNDERRUN [*2];
    endproperty
    a_under: assert property (p_under)
        else $error("underrun not flagged");

    property p_over;
        rx_evt && rx_pend != '0 |=> RX_OVERRUN;
    endproperty
    a_over: assert property (p_over)
        else $error("overrun not flagged");

    property p_rd_order;
        dp_rd_take |=> DP_RD_VALID && DP_RD_DATA == $past(rd_pick_w);
    endproperty
    a_rd_order: assert property (p_rd_order)
        else $error("data port read returned wrong serializer");

    property p_one_req;
        TX_DMA_REQUEST |=> !TX_DMA_REQUEST;
    endproperty
    a_one_req: assert property (p_one_req)
        else $error("tx request longer than one clock");
endmodule

/* File: bench/aport_dma_model.sv */
`timescale 1ns/1ps

// dma master on the single-address data port
module aport_dma_model
(
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic [3:0]  slow,
    input  wire logic [3:0]  extra,
    input  wire logic [31:0] seed,
    input  wire logic [7:0]  tx_mask,
    input  wire logic [7:0]  rx_mask,
    input  wire logic        tx_req,
    input  wire logic        rx_req,
    input  wire logic        wr_ready,
    output logic             wr_valid,
    output logic [31:0]      wr_data,
    output logic             rd_req,
    input  wire logic        rd_valid,
    input  wire logic [31:0] rd_data
);
    logic [31:0] rxq[$];            // words seen on the read side
    int          n;                 // writes per service
    int          m;                 // reads per service

    initial
    begin
        wr_valid = 1'b0;
        wr_data  = 32'h0000_0000;
        rd_req   = 1'b0;
    end

    // writes: sampled on the falling edge to stay clear of register updates
    always @(negedge clk)
        if (tx_req && en)
        begin
            repeat (slow) @(negedge clk);
            n = $countones(tx_mask) + extra;
            for (int k = 0; k < n; k++)
            begin
                @(negedge clk);
                wr_valid = 1'b1;
                wr_data  = seed + k;
                while (!wr_ready) @(negedge clk);
                @(posedge clk);
            end
            @(negedge clk);
            // released bus shows inverted data, never the last word
            wr_valid = 1'b0;
            wr_data  = ~wr_data;
        end

    // reads: request held for one edge per active receiver
    always @(negedge clk)
        if (rx_req && en)
        begin
            repeat (slow) @(negedge clk);
            m = $countones(rx_mask);
            if (m != 0)
            begin
                rd_req = 1'b1;
                repeat (m) @(negedge clk);
                rd_req = 1'b0;
            end
        end

    // capture returned words in arrival order
    always @(negedge clk)
        if (rd_valid)
            rxq.push_back(rd_data);
endmodule

/* File: bench/test_audio_port_buffer_service.sv */
`timescale 1ns/1ps

module test_audio_port_buffer_service;
    // one row: serializer setup, service speed, irq enables tx/rx
    typedef struct {
        logic [7:0] act;
        logic [7:0] istx;
        logic [3:0] slow;
        logic [1:0] ien;
    } row_s;
    row_s rows[3] = '{'{8'hFF, 8'h0F, 4'h0, 2'h0},
                      '{8'hFF, 8'hB1, 4'h6, 2'h3},
                      '{8'h5A, 8'h18, 4'h0, 2'h2}};
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    logic             bclk = 1'b0;
    logic             slot_end = 1'b0;   // both directions end together
    logic [7:0][31:0] rxd = '0;
    logic [7:0][31:0] txd;
    logic [7:0]       act = 8'hFF;
    logic [7:0]       istx = 8'h0F;
    logic             txsel = 1'b0;
    logic             rxsel = 1'b0;
    logic             tien = 1'b1;
    logic             rien = 1'b1;
    logic             txclr = 1'b0;
    logic             rxclr = 1'b0;
    logic             eclr = 1'b0;
    logic             cbw = 1'b0;
    logic             cbr = 1'b0;
    logic [2:0]       cba = 3'h0;
    logic [31:0]      cbwd = 32'h0000_0000;
    logic [31:0]      seed = 32'h0000_0000;
    logic             en = 1'b1;
    logic [3:0]       slow = 4'h0;
    logic [3:0]       extra = 4'h0;
    logic             txf, rxf, txr, rxr, txi, rxi, und, ovr;
    logic             wv, wrdy, rreq, rv, cbv;
    logic [31:0]      wd, rd, cbrd;
    int               n_errors = 0;
    int               checked = 0;
    int               cyc = 0;
    int               j;

    audio_port_buffer_service u_dut (.REF_CLK(clk), .SRST(srst),
        .TX_BIT_CLOCK(bclk), .TX_SLOT_END(slot_end),
        .RX_SLOT_END(slot_end), .RX_SHIFT_DATA(rxd), .TX_SHIFT_DATA(txd),
        .SER_ACTIVE(act), .SER_IS_TX(istx), .TX_PORT_SELECT(txsel),
        .RX_PORT_SELECT(rxsel), .TX_IRQ_ENABLE(tien), .RX_IRQ_ENABLE(rien),
        .TX_READY_CLEAR(txclr), .RX_READY_CLEAR(rxclr), .ERR_CLEAR(eclr),
        .TX_READY_FLAG(txf), .RX_READY_FLAG(rxf), .TX_DMA_REQUEST(txr),
        .RX_DMA_REQUEST(rxr), .TX_IRQ(txi), .RX_IRQ(rxi),
        .TX_UNDERRUN(und), .RX_OVERRUN(ovr), .DP_WR_VALID(wv),
        .DP_WR_READY(wrdy), .DP_WR_DATA(wd), .DP_RD_REQ(rreq),
        .DP_RD_VALID(rv), .DP_RD_DATA(rd), .CB_ADDR(cba), .CB_WR(cbw),
        .CB_WDATA(cbwd), .CB_RD(cbr), .CB_RVALID(cbv), .CB_RDATA(cbrd));

    aport_dma_model u_dma (.clk(clk), .en(en), .slow(slow), .extra(extra),
        .seed(seed), .tx_mask(act & istx), .rx_mask(act & ~istx),
        .tx_req(txr), .rx_req(rxr), .wr_ready(wrdy), .wr_valid(wv),
        .wr_data(wd), .rd_req(rreq), .rd_valid(rv), .rd_data(rd));

    // system clock, 25 ns
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // hang guard: far above the roughly 750 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            $display("BAD run length expected end seen still running");
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic done(input string nm);
        $display("test %s ended, %0d mismatches so far", nm, n_errors);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one bit clock period, slot boundary on its rising edge
    task automatic slot();
        int ntx;
        int nrx;
        ntx = 0;
        nrx = 0;
        @(negedge clk);
        slot_end = 1'b1;
        repeat (2) @(negedge clk);
        bclk = 1'b1;
        for (int d = 1; d <= 12; d++)
        begin
            @(negedge clk);
            // link clock then stands still until the next slot
            if (d == 4)
            begin
                bclk = 1'b0;
                slot_end = 1'b0;
            end
            if (txr)
            begin
                ntx++;
                chk("tx latency", 1, d <= 5);
                chk("tx flag set", 1, txf);
                chk("tx irq", tien, txi);
            end
            if (rxr)
            begin
                nrx++;
                chk("rx latency", 1, d <= 5);
                chk("rx flag set", 1, rxf);
                chk("rx irq", rien, rxi);
            end
        end
        chk("tx requests", 1, ntx);
        chk("rx requests", 1, nrx);
        repeat (40) @(negedge clk);
    endtask

    // one configuration bus access; reads are compared
    task automatic cb(input logic wr, input logic [2:0] a,
                      input logic [31:0] d);
        @(negedge clk);
        cba  = a;
        cbw  = wr;
        cbr  = !wr;
        cbwd = d;
        @(negedge clk);
        cbw = 1'b0;
        cbr = 1'b0;
        if (!wr)
            chk("cb read", {1'b1, d}, {cbv, cbrd});
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(negedge clk);
        chk("reset outs", 0, {txf, rxf, txr, rxr, txi, rxi, und, ovr});
        chk("reset wr ready", 1, wrdy);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        done("reset");
        // ordinary service through the data port, one row each
        foreach (rows[r])
        begin
            act  = rows[r].act;
            istx = rows[r].istx;
            slow = rows[r].slow;
            {tien, rien} = rows[r].ien;
            seed = 32'hA000_0000 + 32'(r * 256);
            for (int i = 0; i < 8; i++)
                rxd[i] = 32'hB000_0000 + 32'(r * 16 + i);
            u_dma.rxq.delete();
            slot();
            j = 0;
            for (int i = 0; i < 8; i++)
                if (act[i] && !istx[i])
                begin
                    chk("rx word", rxd[i], u_dma.rxq[j]);
                    j++;
                end
            chk("rx reads", j, u_dma.rxq.size());
            chk("tx flag clear", 0, txf);
            chk("rx flag clear", 0, rxf);
            // config change may leave a stale error behind
            eclr = 1'b1;
            @(negedge clk);
            eclr = 1'b0;
            slot();
            j = 0;
            for (int i = 0; i < 8; i++)
                if (act[i] && istx[i])
                begin
                    chk("tx word", seed + j, txd[i]);
                    j++;
                end
            chk("no underrun", 0, und);
            chk("no overrun", 0, ovr);
            done("row");
        end
        // unserved slots: requests repeat, errors rise, clears work
        act  = 8'hFF;
        istx = 8'h0F;
        en   = 1'b0;
        slot();
        slot();
        chk("underrun", 1, und);
        chk("overrun", 1, ovr);
        rien = 1'b0;
        @(negedge clk);
        chk("rx irq masked", 0, rxi);
        rien = 1'b1;
        txclr = 1'b1;
        @(negedge clk);
        txclr = 1'b0;
        chk("rx irq on", 1, rxi);
        rxclr = 1'b1;
        eclr  = 1'b1;
        @(negedge clk);
        rxclr = 1'b0;
        eclr  = 1'b0;
        @(negedge clk);
        chk("tx flag cleared", 0, txf);
        chk("rx flag cleared", 0, rxf);
        chk("errors cleared", 0, {und, ovr});
        done("unserved");
        // configuration bus, exact address per serializer
        txsel = 1'b1;
        rxsel = 1'b1;
        for (int i = 0; i < 8; i++)
            rxd[i] = 32'hC000_0000 + 32'(i);
        slot();
        for (int i = 7; i >= 4; i--)
        begin
            chk("rx flag held", 1, rxf);
            cb(1'b0, 3'(i), rxd[i]);
        end
        for (int i = 3; i >= 0; i--)
            cb(1'b1, 3'(i), 32'hCB00_0000 + 32'(i));
        repeat (2) @(negedge clk);
        chk("rx flag by read", 0, rxf);
        chk("tx flag by write", 0, txf);
        slot();
        for (int i = 0; i < 4; i++)
            chk("cb tx word", 32'hCB00_0000 + i, txd[i]);
        done("config bus");
        // fill the write store until it refuses, then drain it
        txsel = 1'b0;
        rxsel = 1'b0;
        en    = 1'b1;
        extra = 4'h4;
        seed  = 32'hF1F0_0000;
        slot();
        chk("store full", 0, wrdy);
        en = 1'b0;
        slot();
        chk("store drained", 1, wrdy);
        chk("tx flag drained", 0, txf);
        slot();
        for (int i = 0; i < 4; i++)
            chk("queued word", seed + 4 + i, txd[i]);
        done("store");
        give_verdict();
    end
endmodule
